// ### logic/iic_conditioner.sv
/*
  Isolated input conditioner: eight channels of threshold, polarity, delay
  and rise tally, reached over APB.
  Assumes the digitiser presents each channel voltage in mV on i_volt_mv,
  synchronous to i_sys_clk.
*/
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "iic_defines.svh"

// Function
// - Eight channels numbered after earlier modules
// - Evaluate each channel every 5 ms
// - Polarity: 0 normally open, 1 closed
// - Above activation threshold activates when open
// - Above activation threshold deactivates when closed
// - Below release threshold opposite action
// - Thresholds held independently per channel
// - Activation delay postpones rise, ms steps
// - Fall delay postpones fall, ms steps
// - AC mode adds 30 ms fall delay
// - AC mode release is 10 % activation
// - 32-bit tally of rises per channel
// - Writing 1 clears the channel tally
// - Measured voltage readable in mV
module iic_conditioner
  import iic_pkg::*;
#(
  parameter int NUM_CH     = 8,
  parameter int CYCLE_CLKS = `IIC_CYCLE_CLKS,
  parameter int CH_BASE    = 0
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_resetn,
  input  wire logic [NUM_CH*20-1:0] i_volt_mv,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic      [NUM_CH-1:0]    o_state,
  output logic      [7:0]           o_first_index
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  iic_cfg_type   cfg        [NUM_CH];
  iic_cfg_type   next_cfg   [NUM_CH];
  iic_state_type st         [NUM_CH];
  iic_state_type next_st    [NUM_CH];
  logic [23:0]   timer      [NUM_CH];
  logic [23:0]   next_timer [NUM_CH];
  logic [31:0]   tally      [NUM_CH];
  logic [31:0]   next_tally [NUM_CH];
  logic [19:0]   volt       [NUM_CH];
  logic [19:0]   next_volt  [NUM_CH];
  logic [NUM_CH-1:0] state_q;
  logic [NUM_CH-1:0] next_state_q;
  logic [22:0]   div_cnt;
  logic [22:0]   next_div_cnt;
  logic          tick;
  logic [31:0]   next_prdata;
  logic          next_pslverr;
  logic          wr_acc;
  logic [2:0]    reg_sel;
  logic [3:0]    ch_sel;
  logic          ch_hit;
  logic          glob_hit;

  assign pready        = 1'b1;
  assign o_state       = state_q;
  assign o_first_index = CH_BASE[7:0] + 8'h01;

  // --------------------------------------------------------------------------
  // Program cycle divider
  // --------------------------------------------------------------------------
  // One tick every 5 ms
  always_comb begin
    tick         = (div_cnt == 23'(CYCLE_CLKS - 1));
    next_div_cnt = tick ? 23'h000000 : div_cnt + 23'h000001;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      div_cnt <= 23'h000000;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  always_comb begin
    reg_sel  = paddr[4:2];
    ch_sel   = paddr[8:5];
    ch_hit   = (paddr[11:9] == 3'h0) && (ch_sel < 4'(NUM_CH)) && (paddr[1:0] == 2'h0);
    glob_hit = (paddr == `IIC_GLOBAL_STATE);
    wr_acc   = psel && penable && pwrite;
  end

  // --------------------------------------------------------------------------
  // Channel evaluation, settings and tallies
  // --------------------------------------------------------------------------
  // Delays count in ms but the evaluation only runs every 5 ms, so each
  // tick takes 5 ms off the remaining time; resolution is one cycle.
  always_comb begin
    logic        energ;
    logic        deenerg;
    logic        want_on;
    logic        want_off;
    logic [15:0] rel;
    logic [23:0] fall_ms;
    logic [19:0] thr_mv;
    logic [19:0] rel_mv;
    energ = 1'b0; deenerg = 1'b0; want_on = 1'b0; want_off = 1'b0;
    rel = 16'h0000; fall_ms = 24'h000000; thr_mv = 20'h00000; rel_mv = 20'h00000;
    next_state_q = state_q;
    for (int c = 0; c < NUM_CH; c++) begin
      next_cfg[c]   = cfg[c];
      next_st[c]    = st[c];
      next_timer[c] = timer[c];
      next_tally[c] = tally[c];
      next_volt[c]  = i_volt_mv[c*20 +: 20];
      // AC forces release to a tenth
      rel = cfg[c].alternating_supply_option ? (cfg[c].act_thr / 16'h000A) : cfg[c].rel_thr;
      // AC adds 30 ms to fall
      fall_ms = cfg[c].fall_delay_setting
              + (cfg[c].alternating_supply_option ? 24'(`IIC_AC_EXTRA_MS) : 24'h000000);
      // Per-channel thresholds, 0.1 V to mV
      thr_mv = 20'(cfg[c].act_thr) * 20'h00064;
      rel_mv = 20'(rel) * 20'h00064;
      energ   = volt[c] > thr_mv;
      deenerg = volt[c] < rel_mv;
      want_on  = cfg[c].polarity_nc ? deenerg : energ;
      want_off = cfg[c].polarity_nc ? energ : deenerg;
      if (tick) begin
        case (st[c])
          IIC_IDLE: begin
            if (!state_q[c] && want_on) begin
              next_st[c] = IIC_RISE;
              next_timer[c] = cfg[c].act_dly;
            end else if (state_q[c] && want_off) begin
              next_st[c] = IIC_FALL;
              next_timer[c] = fall_ms;
            end
          end
          IIC_RISE: begin
            if (!want_on) begin
              next_st[c] = IIC_IDLE;
            end else if (timer[c] <= 24'(`IIC_CYCLE_MS)) begin
              next_st[c] = IIC_IDLE;
            end else begin
              next_timer[c] = timer[c] - 24'(`IIC_CYCLE_MS);
            end
          end
          IIC_FALL: begin
            if (!want_off) begin
              next_st[c] = IIC_IDLE;
            end else if (timer[c] <= 24'(`IIC_CYCLE_MS)) begin
              next_st[c] = IIC_IDLE;
            end else begin
              next_timer[c] = timer[c] - 24'(`IIC_CYCLE_MS);
            end
          end
          default: begin
            next_st[c] = IIC_IDLE;
          end
        endcase
        // Expiry of a delay including zero: state changes this tick
        // Rise after activation delay
        if (!state_q[c] && want_on
            && ((st[c] == IIC_IDLE && cfg[c].act_dly < 24'(`IIC_CYCLE_MS))
             || (st[c] == IIC_RISE && timer[c] <= 24'(`IIC_CYCLE_MS)))) begin
          next_state_q[c] = 1'b1;
          next_st[c]      = IIC_IDLE;
        end
        if (state_q[c] && want_off
            && ((st[c] == IIC_IDLE && fall_ms < 24'(`IIC_CYCLE_MS))
             || (st[c] == IIC_FALL && timer[c] <= 24'(`IIC_CYCLE_MS)))) begin
          next_state_q[c] = 1'b0;
          next_st[c]      = IIC_IDLE;
        end
      end
      // Software writes to this channel
      if (wr_acc && ch_hit && (ch_sel == 4'(c))) begin
        case (reg_sel)
          `IIC_OFS_CFG: begin
            next_cfg[c].polarity_nc = pwdata[`IIC_CFG_POL_BIT];
            next_cfg[c].alternating_supply_option = pwdata[`IIC_CFG_AC_BIT];
          end
          `IIC_OFS_THR: begin
            next_cfg[c].act_thr = pwdata[15:0];
            next_cfg[c].rel_thr = pwdata[31:16];
          end
          `IIC_OFS_ACT_DLY:  next_cfg[c].act_dly = pwdata[23:0];
          `IIC_OFS_FALL_DLY: next_cfg[c].fall_delay_setting = pwdata[23:0];
          default: ;
        endcase
      end
      // Count each rise of the state
      if (next_state_q[c] && !state_q[c]) begin
        next_tally[c] = tally[c] + 32'h00000001;
      end else if (wr_acc && ch_hit && (ch_sel == 4'(c)) && (reg_sel == `IIC_OFS_CLEAR)
                   && (pwdata == `IIC_CLEAR_CMD)) begin
        // Clear command zeroes tally; a coincident rise wins
        next_tally[c] = 32'h00000000;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_q <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        cfg[c].polarity_nc               <= 1'b0;
        cfg[c].alternating_supply_option <= 1'b0;
        cfg[c].act_thr                   <= `IIC_ACT_THR_RST;
        cfg[c].rel_thr                   <= `IIC_REL_THR_RST;
        cfg[c].act_dly                   <= `IIC_DLY_RST;
        cfg[c].fall_delay_setting        <= `IIC_DLY_RST;
        st[c]    <= IIC_IDLE;
        timer[c] <= 24'h000000;
        tally[c] <= 32'h00000000;
        volt[c]  <= 20'h00000;
      end
    end else begin
      state_q <= next_state_q;
      for (int c = 0; c < NUM_CH; c++) begin
        cfg[c]   <= next_cfg[c];
        st[c]    <= next_st[c];
        timer[c] <= next_timer[c];
        tally[c] <= next_tally[c];
        volt[c]  <= next_volt[c];
      end
    end
  end

  // --------------------------------------------------------------------------
  // APB read path
  // --------------------------------------------------------------------------
  // Read data registered in the setup cycle, so zero wait states
  always_comb begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      if (glob_hit) begin
        next_prdata = 32'(state_q);
      end else if (ch_hit) begin
        case (reg_sel)
          `IIC_OFS_CFG: begin
            next_prdata[`IIC_CFG_POL_BIT] = cfg[ch_sel[2:0]].polarity_nc;
            next_prdata[`IIC_CFG_AC_BIT]  = cfg[ch_sel[2:0]].alternating_supply_option;
          end
          `IIC_OFS_THR:      next_prdata = {cfg[ch_sel[2:0]].rel_thr, cfg[ch_sel[2:0]].act_thr};
          `IIC_OFS_ACT_DLY:  next_prdata = 32'(cfg[ch_sel[2:0]].act_dly);
          `IIC_OFS_FALL_DLY: next_prdata = 32'(cfg[ch_sel[2:0]].fall_delay_setting);
          `IIC_OFS_TALLY:    next_prdata = tally[ch_sel[2:0]];
          `IIC_OFS_VOLT:     next_prdata = 32'(volt[ch_sel[2:0]]);
          `IIC_OFS_STATUS:   next_prdata = {29'h0, st[ch_sel[2:0]] != IIC_IDLE, 1'b0,
                                            state_q[ch_sel[2:0]]};
          default:           next_prdata = 32'h00000000;
        endcase
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (psel && penable) begin
      next_prdata  = prdata;
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule : iic_conditioner
`default_nettype wire

// ### inc/iic_defines.svh
/*
  Offsets, reset values and timing counts for the isolated input conditioner.
  Assumes a 10 MHz system clock and APB register access.
*/
`ifndef IIC_DEFINES_SVH
`define IIC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define IIC_CLK_HZ          10000000
`define IIC_CYCLE_MS        5
`define IIC_CYCLE_CLKS      ((`IIC_CLK_HZ / 1000) * `IIC_CYCLE_MS)
`define IIC_AC_EXTRA_MS     30
`define IIC_AC_EXTRA_TICKS  (`IIC_AC_EXTRA_MS / `IIC_CYCLE_MS)

// ----------------------------------------------------------------------------
// Reset values (thresholds in 0.1 V, delays in ms)
// ----------------------------------------------------------------------------
`define IIC_ACT_THR_RST     16'h0370
`define IIC_REL_THR_RST     16'h0258
`define IIC_DLY_RST         24'h000000

// ----------------------------------------------------------------------------
// Register map: 8 words per channel, channel base = ch * 0x20
// ----------------------------------------------------------------------------
`define IIC_CH_STRIDE       12'h020
`define IIC_OFS_CFG         3'h0
`define IIC_OFS_THR         3'h1
`define IIC_OFS_ACT_DLY     3'h2
`define IIC_OFS_FALL_DLY    3'h3
`define IIC_OFS_TALLY       3'h4
`define IIC_OFS_CLEAR       3'h5
`define IIC_OFS_VOLT        3'h6
`define IIC_OFS_STATUS      3'h7
`define IIC_GLOBAL_STATE    12'h100
`define IIC_CFG_POL_BIT     0
`define IIC_CFG_AC_BIT      1
`define IIC_CLEAR_CMD       32'h00000001

`endif

// ### inc/iic_pkg.sv
/*
  Types shared by the isolated input conditioner.
  Assumes iic_defines.svh is compiled alongside.
*/
package iic_pkg;

  // Per-channel settings as written by software
  typedef struct packed {
    logic        polarity_nc;
    logic        alternating_supply_option;
    logic [15:0] act_thr;
    logic [15:0] rel_thr;
    logic [23:0] act_dly;
    logic [23:0] fall_delay_setting;
  } iic_cfg_type;

  // Delay filter state per channel
  typedef enum logic [2:0] {
    IIC_IDLE  = 3'b001,
    IIC_RISE  = 3'b010,
    IIC_FALL  = 3'b100
  } iic_state_type;

endpackage : iic_pkg

// ### sim/iic_field_model.sv
/*
  Field side: contacts that put a voltage on each input channel.
  Assumes the bench sets each level in mV; packs them for the digitiser port.
*/
`timescale 1ns/1ps
`default_nettype none
module iic_field_model (
  input  wire logic [19:0]  i_level_mv [8],
  output logic      [159:0] o_volt_mv
);
  // Pack channel c at [c*20+:20], as the conditioner expects
  always_comb begin
    for (int c = 0; c < 8; c++) o_volt_mv[c*20+:20] = i_level_mv[c];
  end
endmodule : iic_field_model
`default_nettype wire

// ### sim/iic_cond_monitor.sv
/*
  Port checker for the input conditioner.
  Assumes bind onto iic_conditioner; CYCLE_CLKS of at least 9.
*/
`timescale 1ns/1ps
`default_nettype none
module iic_cond_monitor
  import iic_pkg::*;
#(
  parameter int NUM_CH  = 8,
  parameter int CH_BASE = 0
) (
  input wire logic              i_sys_clk,
  input wire logic              i_resetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [NUM_CH-1:0] o_state,
  input wire logic [7:0]        o_first_index
);
  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // Setup then access of one transfer
  sequence acc_s;
    psel && !penable ##1 psel && penable;
  endsequence
  ready_high_a: assert property (pready) else $error("pready low");
  first_index_a: assert property (o_first_index == 8'(CH_BASE + 1))
    else $error("first index wrong");
  tick_spacing_a: assert property ($changed(o_state) |=> $stable(o_state)[*8])
    else $error("state changed between ticks");
  misalign_err_a: assert property (acc_s ##0 (paddr[1:0] != 2'h0) |-> pslverr)
    else $error("misaligned access accepted");
  misalign_rd_a: assert property (acc_s ##0 (!pwrite && paddr[1:0] != 2'h0) |-> prdata == 32'h0)
    else $error("misaligned read not zero");
  high_err_a: assert property ((psel && penable && paddr > 12'h100) |-> pslverr)
    else $error("unmapped access accepted");
  high_rd_a: assert property ((psel && penable && !pwrite && paddr > 12'h100) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  mapped_ok_a: assert property (acc_s ##0 (paddr <= 12'h100 && paddr[1:0] == 2'h0) |-> !pslverr)
    else $error("mapped access refused");
endmodule : iic_cond_monitor
bind iic_conditioner iic_cond_monitor #(.NUM_CH(NUM_CH), .CH_BASE(CH_BASE)) u_mon (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .o_state(o_state), .o_first_index(o_first_index));
`default_nettype wire

// ### sim/tb.sv
/*
  Self-checking bench for the input conditioner.
  Assumes a short cycle of 20 clocks; field voltages come from the model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb import iic_pkg::*;;
  localparam int CC = 20;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  st, fi;
  logic [19:0] mv [8];
  logic [159:0] volt;
  int          err_total, num_checks;
  iic_field_model u_fld (.i_level_mv(mv), .o_volt_mv(volt));
  iic_conditioner #(.CYCLE_CLKS(CC)) dut (.i_sys_clk(clk), .i_resetn(rstn), .i_volt_mv(volt),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_state(st), .o_first_index(fi));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // One APB transfer; held until pready is seen, bounded wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Access phase: answer taken at the rising edge that shows pready high
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never drives psel twice in one step
    @(posedge clk);
    if (n >= 50) begin
      err_total++;
      complete_run();
    end
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check($sformatf("addr_%h", a), q, x);
  endtask : rdc
  task automatic tk(input int n);
    repeat (n * CC) @(posedge clk);
  endtask : tk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_defaults();
    rdc(12'h060, 32'h0);
    rdc(12'h064, 32'h02580370);
    rdc(12'h068, 32'h0);
    rdc(12'h06C, 32'h0);
    rdc(12'h070, 32'h0);
    check("first", {24'h0, fi}, 32'h1);
    apb(1'b0, 12'h104, 32'h0);
    check("err_hi", {31'h0, e}, 32'h1);
    apb(1'b0, 12'h002, 32'h0);
    check("err_mis", {31'h0, e}, 32'h1);
    $display("defaults done");
  endtask : t_defaults
  task automatic t_open();
    mv[0] <= 20'h15F90;
    tk(2);
    check("st0", {31'h0, st[0]}, 32'h1);
    rdc(12'h100, 32'h1);
    mv[0] <= 20'h11170;
    tk(2);
    check("st0", {31'h0, st[0]}, 32'h1);
    mv[0] <= 20'h0C350;
    tk(2);
    check("st0", {31'h0, st[0]}, 32'h0);
    mv[0] <= 20'h15F90;
    tk(2);
    rdc(12'h010, 32'h2);
    apb(1'b1, 12'h014, 32'h00000001);
    rdc(12'h010, 32'h0);
    $display("open done");
  endtask : t_open
  task automatic t_closed();
    apb(1'b1, 12'h020, 32'h00000001);
    tk(2);
    check("st1", {31'h0, st[1]}, 32'h1);
    mv[1] <= 20'h15F90;
    tk(2);
    check("st1", {31'h0, st[1]}, 32'h0);
    rdc(12'h030, 32'h1);
    $display("closed done");
  endtask : t_closed
  task automatic t_indep();
    apb(1'b1, 12'h044, {16'h012C, 16'h01F4});
    mv[2] <= 20'h0EA60;
    mv[3] <= 20'h0EA60;
    tk(2);
    check("st2", {30'h0, st[3:2]}, 32'h1);
    $display("indep done");
  endtask : t_indep
  task automatic t_delay();
    apb(1'b1, 12'h088, 32'h00000014);
    apb(1'b1, 12'h08C, 32'h0000000A);
    mv[4] <= 20'h15F90;
    tk(2);
    mv[4] <= 20'h00000;
    tk(6);
    check("st4", {31'h0, st[4]}, 32'h0);
    mv[4] <= 20'h15F90;
    tk(3);
    check("st4", {31'h0, st[4]}, 32'h0);
    tk(3);
    check("st4", {31'h0, st[4]}, 32'h1);
    mv[4] <= 20'h00000;
    tk(1);
    check("st4", {31'h0, st[4]}, 32'h1);
    tk(3);
    check("st4", {31'h0, st[4]}, 32'h0);
    $display("delay done");
  endtask : t_delay
  task automatic t_ac();
    apb(1'b1, 12'h0A0, 32'h00000002);
    mv[5] <= 20'h15F90;
    tk(2);
    mv[5] <= 20'h0C350;
    tk(10);
    check("st5", {31'h0, st[5]}, 32'h1);
    mv[5] <= 20'h01388;
    tk(4);
    check("st5", {31'h0, st[5]}, 32'h1);
    tk(5);
    check("st5", {31'h0, st[5]}, 32'h0);
    mv[6] <= 20'h1E240;
    tk(1);
    rdc(12'h0D8, 32'h0001E240);
    $display("ac done");
  endtask : t_ac
  // Main sequence: reset held 20 cycles, then each scenario
  initial begin
    rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    err_total = 0; num_checks = 0;
    for (int c = 0; c < 8; c++) mv[c] = 20'd0;
    repeat (20) @(posedge clk);
    check("st_rst", {24'h0, st}, 32'h0);
    rstn <= 1;
    @(posedge clk);
    t_defaults();
    t_open();
    t_closed();
    t_indep();
    t_delay();
    t_ac();
    complete_run();
  end
endmodule : tb
`default_nettype wire
